// ==== core/tsc_pkg.sv ====
// Shared constants, types and channel decoding for the touch-panel controller.
package tsc_pkg;

  // Control word layout and serial sequencing counts, in link clock cycles.
  localparam logic [3:0] CW_BITS = 4'h7;
  localparam logic [3:0] TRACK_EDGE = 4'h5;
  localparam logic [3:0] ACQ_CYCLES = 4'h3;
  localparam logic [3:0] HOLD_EDGE = TRACK_EDGE + ACQ_CYCLES;
  localparam int RES_HI = 12;
  localparam int RES_LO = 8;

  // Channel codes and power management codes.
  localparam logic [2:0] CH_XP = 3'h1;
  localparam logic [2:0] CH_AUX1 = 3'h2;
  localparam logic [2:0] CH_YP = 3'h5;
  localparam logic [2:0] CH_AUX2 = 3'h6;
  localparam logic [1:0] PD_STAY_ON = 2'h3;

  // Identity word returned by the readout code; the value is arbitrary.
  localparam logic [11:0] ID_DEFAULT = 12'hA5C;

  // Register byte offsets on the bus.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam logic [3:0] REG_IDCODE = 4'hC;

  // Register fields and reset values.
  localparam int CTRL_SAVE = 0;
  localparam int CTRL_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int STAT_INVALID = 7;
  localparam int STAT_BUSY = 8;
  localparam int STAT_TRACK = 9;
  localparam int STAT_XDRV = 10;
  localparam int STAT_YDRV = 11;
  localparam int RES_IS_ID = 16;

  // Analog input selection and reference selection.
  typedef enum logic [2:0] {AIN_NONE, AIN_XP, AIN_YP, AIN_AUX1, AIN_AUX2} ain_t;
  typedef enum logic [1:0] {REF_NONE, REF_EXT, REF_Y, REF_X} ref_t;

  // Received control word, first received bit highest.
  typedef struct packed {
    logic [2:0] channel_select_bits;
    logic low_res;
    logic reference_mode_select;
    logic power_mgmt_bit_high;
    logic power_mgmt_bit_low;
  } cword_t;

  // Routing of the multiplexer, references and panel drivers.
  typedef struct packed {
    ain_t ain;
    ref_t refsel;
    logic x_on;
    logic y_on;
    logic valid;
    logic is_id;
  } route_t;

  // Decodes channel code and reference mode into a route.
  function automatic route_t route_of(input logic [2:0] ch, input logic se);
    route_t r;
    r.ain = AIN_NONE;
    r.refsel = REF_NONE;
    r.x_on = 1'b0;
    r.y_on = 1'b0;
    r.valid = 1'b1;
    r.is_id = 1'b0;
    case ({se, ch})
      {1'b1, CH_XP}:
      begin
        r.ain = AIN_XP;
        r.refsel = REF_EXT;
        r.y_on = 1'b1;
      end
      {1'b1, CH_AUX1}:
      begin
        r.ain = AIN_AUX1;
        r.refsel = REF_EXT;
      end
      {1'b1, CH_YP}:
      begin
        r.ain = AIN_YP;
        r.refsel = REF_EXT;
        r.x_on = 1'b1;
      end
      {1'b1, CH_AUX2}:
      begin
        r.ain = AIN_AUX2;
        r.refsel = REF_EXT;
      end
      {1'b0, CH_XP}:
      begin
        r.ain = AIN_XP;
        r.refsel = REF_Y;
        r.y_on = 1'b1;
      end
      {1'b0, CH_YP}:
      begin
        r.ain = AIN_YP;
        r.refsel = REF_X;
        r.x_on = 1'b1;
      end
      {1'b0, CH_AUX2}:
      begin
        r.is_id = 1'b1;
      end
      default:
      begin
        r.valid = 1'b0;
      end
    endcase
    return r;
  endfunction

endpackage

// ==== core/edge_sync.sv ====
// Two-stage synchroniser with edge detection for pin inputs.
`timescale 1ns/100ps
module edge_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Asynchronous inputs.
  input wire logic [W-1:0] async_in,
  // Synchronised level and one-cycle edge pulses.
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // Only the second stage reads the first stage.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_r <= INIT;
      sync_r <= INIT;
      prev_r <= INIT;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges are seen between the second and third stages.
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule // edge_sync

// ==== core/sar_engine.sv ====
// Successive-approximation sequencer resolving one bit per decision strobe.
`timescale 1ns/100ps
module sar_engine #(
  parameter int N = 12,
  parameter int LO = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Sequencing strobes.
  input wire logic start,
  input wire logic abort,
  input wire logic decide,
  // Decision sources and options.
  input wire logic cmp,
  input wire logic use_id,
  input wire logic [N-1:0] id_code,
  input wire logic low_res,
  // Trial code, result and progress.
  output logic [N-1:0] trial,
  output logic [N-1:0] result,
  output logic bit_r,
  output logic bit_stb,
  output logic active,
  output logic done
);

  localparam int IW = $clog2(N);

  logic [IW-1:0] idx_r;
  logic [N-1:0] cur_mask;
  logic [N-1:0] low_mask;
  logic [IW-1:0] last_idx;
  logic bit_now;
  logic at_last;
  logic [N-1:0] trial_nxt;

  // Decision, bit position and next trial code.
  assign bit_now = use_id ? id_code[idx_r] : cmp;
  assign last_idx = low_res ? IW'(N - LO) : '0;
  assign at_last = (idx_r == last_idx);
  assign cur_mask = {{(N-1){1'b0}}, 1'b1} << idx_r;
  assign low_mask = at_last ? '0 : (cur_mask >> 1);
  assign trial_nxt = (bit_now ? trial : (trial & ~cur_mask)) | low_mask;

  // Bits resolve from the top downward, one per decision strobe.
  always_ff @(posedge clk)
  begin
    if (!rstn || abort)
    begin
      idx_r <= '0;
      trial <= '0;
      result <= '0;
      bit_r <= 1'b0;
      bit_stb <= 1'b0;
      active <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      bit_stb <= 1'b0;
      done <= 1'b0;
      if (start)
      begin
        active <= 1'b1;
        idx_r <= IW'(N - 1);
        trial <= {1'b1, {(N-1){1'b0}}};
        result <= '0;
      end
      else if (active && decide)
      begin
        result <= result | (bit_now ? cur_mask : '0);
        trial <= trial_nxt;
        bit_r <= bit_now;
        bit_stb <= 1'b1;
        if (at_last)
        begin
          active <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          idx_r <= idx_r - 1'b1;
        end
      end
    end
  end

endmodule // sar_engine

// ==== core/touch_ctrl.sv ====
// Touch-panel digitizer control: serial link, multiplexer, drivers, conversion.
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module touch_ctrl #(
  // Identity word; the default value is arbitrary.
  parameter logic [11:0] ID_CODE = tsc_pkg::ID_DEFAULT
) (
  // System clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial link pins.
  input wire logic cs_n_pin,
  input wire logic serial_conversion_clock,
  input wire logic din_pin,
  output logic dout_o,
  output logic dout_oe,
  output logic busy_o,
  output logic busy_oe,
  // Analog front end.
  input wire logic cmp_above,
  output logic [11:0] dac_code,
  output logic track_o,
  output logic hold_o,
  output tsc_pkg::ain_t ain_sel,
  output tsc_pkg::ref_t ref_sel,
  output logic x_drv_on,
  output logic y_drv_on,
  output logic adc_power_down
);

  typedef enum logic {ST_IDLE, ST_RECV} rx_state_t;

  // Synchronised link pins and comparator.
  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic cs_high;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic din_lvl;
  logic cmp_lvl;

  // Receiver and configuration state.
  rx_state_t rx_r;
  logic [3:0] cnt_r;
  logic [6:0] cw_r;
  tsc_pkg::cword_t cfg_r;
  tsc_pkg::route_t route_r;
  tsc_pkg::route_t route_now;
  logic [1:0] ctrl_r;
  logic [11:0] result_r;
  logic result_id_r;
  logic track_r;
  logic hold_r;
  logic xdrv_r;
  logic ydrv_r;
  logic pend_r;
  logic dout_r;
  logic pdn_r;

  // Conversion engine signals.
  logic sar_start;
  logic sar_abort;
  logic [11:0] sar_trial;
  logic [11:0] sar_result;
  logic sar_bit;
  logic sar_stb;
  logic sar_active;
  logic sar_done;

  // Bus signals.
  logic ack_r;
  logic [31:0] dat_r;
  logic bus_req;
  logic wr_fire;
  logic [31:0] rd_mux;
  logic [31:0] stat_word;

  // Sequencing strobes.
  logic link_on;
  logic track_go;
  logic hold_go;
  logic start_seen;
  logic se_save;
  logic stay_on;

  // Pin order in the synchroniser: comparator, data in, clock, select.
  edge_sync #(
    .W(4),
    .INIT(4'h1)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in({cmp_above, din_pin, serial_conversion_clock, cs_n_pin}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Named views of the synchronised pins.
  assign cs_high = pin_lvl[0] || !ctrl_r[tsc_pkg::CTRL_EN];
  assign cs_rise = pin_rise[0];
  assign sclk_rise = pin_rise[1] && !cs_high;
  assign sclk_fall = pin_fall[1] && !cs_high;
  assign din_lvl = pin_lvl[2];
  assign cmp_lvl = pin_lvl[3];
  assign link_on = !cs_high;

  // Sequencing decodes on the link clock edges.
  assign start_seen = (rx_r == ST_IDLE) && sclk_rise && din_lvl;
  assign track_go = (rx_r == ST_RECV) && sclk_fall
    && (cnt_r == tsc_pkg::TRACK_EDGE);
  assign hold_go = (rx_r == ST_RECV) && sclk_fall
    && (cnt_r == tsc_pkg::HOLD_EDGE);
  assign route_now = tsc_pkg::route_of(cw_r[4:2], cw_r[0]);
  assign sar_start = hold_go;
  assign sar_abort = cs_high;
  assign se_save = ctrl_r[tsc_pkg::CTRL_SAVE];
  assign stay_on = (cfg_r.power_mgmt_bit_high && cfg_r.power_mgmt_bit_low);

  // Receiver: start bit, seven control bits, then acquisition cycles.
  always_ff @(posedge clk)
  begin
    if (!rstn || cs_high)
    begin
      rx_r <= ST_IDLE;
      cnt_r <= '0;
      cw_r <= '0;
    end
    else
    begin
      unique case (rx_r)
        ST_IDLE:
        begin
          if (start_seen)
          begin
            rx_r <= ST_RECV;
            cnt_r <= '0;
          end
        end
        ST_RECV:
        begin
          if (sclk_rise)
          begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r < tsc_pkg::CW_BITS)
            begin
              cw_r <= {cw_r[5:0], din_lvl};
            end
          end
          if (hold_go)
          begin
            rx_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Route, track and hold state for the analog front end.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      route_r <= tsc_pkg::route_of('0, 1'b0);
      cfg_r <= '0;
      track_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else if (cs_high)
    begin
      track_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else
    begin
      if (track_go)
      begin
        route_r <= route_now;
        track_r <= 1'b1;
      end
      if (hold_go)
      begin
        cfg_r <= tsc_pkg::cword_t'(cw_r);
        track_r <= 1'b0;
        hold_r <= 1'b1;
      end
      else if (sar_done)
      begin
        hold_r <= 1'b0;
      end
    end
  end

  // Panel drivers: on at tracking, held per mode and power bits.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      xdrv_r <= 1'b0;
      ydrv_r <= 1'b0;
    end
    else if (track_go)
    begin
      xdrv_r <= route_now.x_on;
      ydrv_r <= route_now.y_on;
    end
    else if (hold_go && cw_r[2] && se_save
      && cw_r[1:0] != tsc_pkg::PD_STAY_ON)
    begin
      xdrv_r <= 1'b0;
      ydrv_r <= 1'b0;
    end
    else if (cs_rise && !stay_on && !hold_r)
    begin
      xdrv_r <= 1'b0;
      ydrv_r <= 1'b0;
    end
  end

  // Conversion engine, fed with the identity word for the readout code.
  sar_engine #(
    .N(tsc_pkg::RES_HI),
    .LO(tsc_pkg::RES_LO)
  ) u_sar (
    .clk(clk),
    .rstn(rstn),
    .start(sar_start),
    .abort(sar_abort),
    .decide(sclk_rise),
    .cmp(cmp_lvl),
    .use_id(route_r.is_id),
    .id_code(ID_CODE),
    .low_res(cfg_r.low_res),
    .trial(sar_trial),
    .result(sar_result),
    .bit_r(sar_bit),
    .bit_stb(sar_stb),
    .active(sar_active),
    .done(sar_done)
  );
  assign dac_code = sar_trial;

  // Serial output: each decided bit on the next falling edge, else zero.
  always_ff @(posedge clk)
  begin
    if (!rstn || cs_high)
    begin
      pend_r <= 1'b0;
      dout_r <= 1'b0;
    end
    else
    begin
      if (sar_stb)
      begin
        pend_r <= 1'b1;
      end
      else if (sclk_fall)
      begin
        pend_r <= 1'b0;
      end
      if (sclk_fall)
      begin
        dout_r <= pend_r ? sar_bit : 1'b0;
      end
    end
  end

  // Pin drivers, power state and captured result.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      dout_oe <= 1'b0;
      busy_o <= 1'b0;
      busy_oe <= 1'b0;
      pdn_r <= 1'b1;
      result_r <= '0;
      result_id_r <= 1'b0;
    end
    else
    begin
      dout_oe <= link_on;
      busy_oe <= link_on;
      busy_o <= sar_active && link_on;
      pdn_r <= !sar_active && !track_r && (rx_r == ST_IDLE)
        && !stay_on;
      if (sar_done)
      begin
        result_r <= sar_result;
        result_id_r <= route_r.is_id;
      end
    end
  end

  assign dout_o = dout_r;
  assign track_o = track_r;
  assign hold_o = hold_r;
  assign ain_sel = route_r.ain;
  assign ref_sel = route_r.refsel;
  assign x_drv_on = xdrv_r;
  assign y_drv_on = ydrv_r;
  assign adc_power_down = pdn_r;

  // Bus decode and read selection.
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wr_fire = bus_req && wb_we_i && ack_r && wb_sel_i[0];
  assign stat_word = {20'h00000, ydrv_r, xdrv_r, track_r, sar_active,
    ~route_r.valid, cfg_r};
  assign rd_mux =
    (wb_adr_i == tsc_pkg::REG_CTRL) ? {30'h00000000, ctrl_r} :
    (wb_adr_i == tsc_pkg::REG_STATUS) ? stat_word :
    (wb_adr_i == tsc_pkg::REG_RESULT) ?
      {15'h0000, result_id_r, 4'h0, result_r} :
    (wb_adr_i == tsc_pkg::REG_IDCODE) ? {20'h00000, ID_CODE} :
    32'h00000000;

  // Bus slave: ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ack_r <= 1'b0;
      dat_r <= '0;
      ctrl_r <= tsc_pkg::CTRL_RESET;
    end
    else
    begin
      ack_r <= bus_req && !ack_r;
      if (bus_req && !ack_r)
      begin
        dat_r <= rd_mux;
      end
      if (wr_fire && wb_adr_i == tsc_pkg::REG_CTRL)
      begin
        ctrl_r <= wb_dat_i[1:0];
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule // touch_ctrl

// ==== bench/touch_ctrl_properties.sv ====
// Concurrent checks on the touch controller's bus, link and front-end ports.
`timescale 1ns/100ps
module touch_ctrl_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Bus handshake.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Link pins.
  input wire logic cs_n_pin,
  input wire logic serial_conversion_clock,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic busy_o,
  input wire logic busy_oe,
  // Front end.
  input wire logic [11:0] dac_code,
  input wire logic track_o,
  input wire logic hold_o,
  input wire tsc_pkg::ain_t ain_sel,
  input wire tsc_pkg::ref_t ref_sel,
  input wire logic x_drv_on,
  input wire logic y_drv_on
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Counts the system cycles of the present tracking window.
  logic [7:0] trk_cnt_r;
  always_ff @(posedge clk)
  begin
    if (!rstn || !track_o)
      trk_cnt_r <= 8'h00;
    else
      trk_cnt_r <= trk_cnt_r + 8'h01;
  end

  // Each request gets exactly one single-cycle acknowledge.
  a_ack_follows_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> wb_ack_o) else $error("bus request not acknowledged");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  // Link outputs are released while chip select stays high.
  a_outputs_released: assert property (cs_n_pin [*4]
    |-> !dout_oe && !busy_oe)
    else $error("link outputs driven with chip select high");
  a_dout_on_fall: assert property ((dout_oe && $changed(dout_o))
    |-> !serial_conversion_clock) else $error("data out moved in high phase");
  // Tracking hands over to hold after exactly three link periods.
  a_track_to_hold: assert property (($fell(track_o) && !cs_n_pin) |-> hold_o)
    else $error("tracking ended without hold");
  a_acq_length: assert property (($fell(track_o) && hold_o)
    |-> trk_cnt_r == 8'h18) else $error("acquisition not three periods");
  a_hold_mid_trial: assert property ($rose(hold_o)
    |-> dac_code == 12'h800 ##1 busy_o) else $error("hold start bad trial");
  // Ratiometric references keep their panel drivers powered.
  a_ratio_drivers: assert property ((track_o || hold_o)
    |-> (ref_sel != tsc_pkg::REF_Y || y_drv_on)
    && (ref_sel != tsc_pkg::REF_X || x_drv_on))
    else $error("ratiometric driver off");
  a_aux_route: assert property ((track_o && ain_sel == tsc_pkg::AIN_AUX1)
    |-> !x_drv_on && !y_drv_on && ref_sel == tsc_pkg::REF_EXT)
    else $error("auxiliary route wrong");
endmodule // touch_ctrl_properties

bind touch_ctrl touch_ctrl_properties u_props (.clk(clk), .rstn(rstn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .cs_n_pin(cs_n_pin), .serial_conversion_clock(serial_conversion_clock),
  .dout_o(dout_o), .dout_oe(dout_oe), .busy_o(busy_o), .busy_oe(busy_oe),
  .dac_code(dac_code), .track_o(track_o), .hold_o(hold_o),
  .ain_sel(ain_sel), .ref_sel(ref_sel), .x_drv_on(x_drv_on),
  .y_drv_on(y_drv_on));

// ==== bench/link_host.sv ====
// Host model that clocks control words in and result bits out of the link.
`timescale 1ns/100ps
module link_host (
  // System clock paces the link clock.
  input wire logic clk,
  // Serial data back from the device.
  input wire logic dout,
  // Link pins driven by the host.
  output logic cs_n,
  output logic sclk,
  output logic din
);
  // The link clock stands low between frames.
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  // Sends lead zeros, then a word, then zeros; keeps bits seen from rise 10.
  task automatic frame(input logic [7:0] w, input int lead,
                       output logic [15:0] got);
    got = 16'h0000;
    @(posedge clk) cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 24 + lead; i++)
    begin
      din <= (i >= lead && i < lead + 8) ? w[7 - (i - lead)] : 1'b0;
      repeat (4) @(posedge clk);
      if (i >= 10 + lead)
        got = {got[14:0], dout};
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
  endtask

  // Ends the frame by raising chip select.
  task automatic release_cs;
    @(posedge clk) cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule // link_host

// ==== bench/tb.sv ====
// Self-checking bench for the touch controller: bus, link host, comparator.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  miscompares++; $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module tb;
  localparam logic [11:0] ID = 12'h3C6; // Arbitrary identity word.
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, cs_n, sclk, din, dout_o, dout_oe, busy_o, busy_oe;
  logic track_o, hold_o, x_drv_on, y_drv_on, adc_power_down;
  logic [11:0] dac_code;
  logic [11:0] vin = 12'h000;
  logic cmp_above = 1'b0;
  logic [15:0] got;
  tsc_pkg::ain_t ain_sel;
  tsc_pkg::ref_t ref_sel;
  wire logic dout_w;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [2:0] se_ch [4] = '{tsc_pkg::CH_XP, tsc_pkg::CH_AUX1,
                            tsc_pkg::CH_YP, tsc_pkg::CH_AUX2};
  tsc_pkg::ain_t se_ain [4] = '{tsc_pkg::AIN_XP, tsc_pkg::AIN_AUX1,
                                tsc_pkg::AIN_YP, tsc_pkg::AIN_AUX2};

  always #50 clk = ~clk;

  // The host sees an undriven line while the device releases data out.
  assign dout_w = dout_oe ? dout_o : 1'bz;

  // Comparator sits half a step above the input so ties cannot matter.
  always @(posedge clk)
    cmp_above <= ({vin, 1'b1} > {dac_code, 1'b0});

  touch_ctrl #(.ID_CODE(ID)) dut (.clk(clk), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cs_n_pin(cs_n),
    .serial_conversion_clock(sclk), .din_pin(din), .dout_o(dout_o),
    .dout_oe(dout_oe), .busy_o(busy_o), .busy_oe(busy_oe),
    .cmp_above(cmp_above), .dac_code(dac_code), .track_o(track_o),
    .hold_o(hold_o), .ain_sel(ain_sel), .ref_sel(ref_sel),
    .x_drv_on(x_drv_on), .y_drv_on(y_drv_on),
    .adc_power_down(adc_power_down));

  link_host u_host (.clk(clk), .dout(dout_w), .cs_n(cs_n), .sclk(sclk),
    .din(din));

  // One classic single cycle; read data is taken at the acknowledge edge.
  task automatic wb_xfer(input logic we, input logic [3:0] adr,
                         input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 50)
      miscompares++;
  endtask

  // Prints the verdict and ends the run.
  task automatic print_verdict;
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  // Main sequence of bus and link scenarios.
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    wb_xfer(1'b0, tsc_pkg::REG_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h00000003, rd)
    wb_xfer(1'b0, tsc_pkg::REG_IDCODE, 32'h0);
    `CHK("idcode", {20'h00000, ID}, rd)
    wb_xfer(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h00000000, rd)
    vin <= 12'h5A3;
    u_host.frame(8'h90, 3, got);
    `CHK("x ratio data", 16'h168C, got)
    `CHK("x ratio ain", tsc_pkg::AIN_XP, ain_sel)
    `CHK("x ratio ref", tsc_pkg::REF_Y, ref_sel)
    `CHK("x ratio ydrv", 1'b1, y_drv_on)
    wb_xfer(1'b0, tsc_pkg::REG_RESULT, 32'h0);
    `CHK("x ratio result", 32'h000005A3, rd)
    wb_xfer(1'b0, tsc_pkg::REG_STATUS, 32'h0);
    `CHK("status word", 7'h10, rd[6:0])
    u_host.release_cs();
    `CHK("pd off ydrv", 1'b0, y_drv_on)
    `CHK("pd off power", 1'b1, adc_power_down)
    for (int k = 0; k < 4; k++)
    begin
      vin <= 12'hFFF >> k;
      u_host.frame({1'b1, se_ch[k], 4'b0100}, 0, got);
      `CHK("se data", {2'b00, 12'hFFF >> k, 2'b00}, got)
      `CHK("se ain", se_ain[k], ain_sel)
      `CHK("se ref", tsc_pkg::REF_EXT, ref_sel)
      `CHK("se drivers", 2'b00, {x_drv_on, y_drv_on})
      u_host.release_cs();
    end
    wb_xfer(1'b1, tsc_pkg::REG_CTRL, 32'h00000002);
    wb_xfer(1'b0, tsc_pkg::REG_CTRL, 32'h0);
    `CHK("ctrl write", 32'h00000002, rd)
    u_host.frame(8'h94, 0, got);
    `CHK("se kept ydrv", 1'b1, y_drv_on)
    u_host.release_cs();
    wb_xfer(1'b1, tsc_pkg::REG_CTRL, 32'h00000003);
    vin <= 12'h9C7;
    u_host.frame(8'hD3, 0, got);
    `CHK("y ratio data", 16'h271C, got)
    `CHK("y ratio ref", tsc_pkg::REF_X, ref_sel)
    u_host.release_cs();
    `CHK("pd on xdrv", 1'b1, x_drv_on)
    `CHK("pd on power", 1'b0, adc_power_down)
    u_host.frame(8'hD8, 0, got);
    `CHK("low res data", 16'h2700, got)
    u_host.release_cs();
    `CHK("pd off xdrv", 1'b0, x_drv_on)
    u_host.frame(8'hE0, 0, got);
    `CHK("id data", {2'b00, ID, 2'b00}, got)
    wb_xfer(1'b0, tsc_pkg::REG_RESULT, 32'h0);
    `CHK("id result", {15'h0000, 1'b1, 4'h0, ID}, rd)
    u_host.release_cs();
    u_host.frame(8'hB0, 0, got);
    wb_xfer(1'b0, tsc_pkg::REG_STATUS, 32'h0);
    `CHK("invalid flag", 1'b1, rd[7])
    `CHK("invalid ain", tsc_pkg::AIN_NONE, ain_sel)
    u_host.release_cs();
    print_verdict();
  end
endmodule // tb
